/* File: rtl/ibc_pkg.sv */
// Package: register map, field positions, reset values and types of the I2C control block
`default_nettype none
package ibc_pkg;
    // Byte offsets of the APB registers
    localparam logic [7:0] CR1_OFF = 8'h00;     // control_register_one
    localparam logic [7:0] CR2_OFF = 8'h04;     // control_register_two
    localparam logic [7:0] IER_OFF = 8'h08;     // interrupt_enable_register
    localparam logic [7:0] SR_OFF = 8'h0c;      // status_register
    localparam logic [7:0] SAR_OFF = 8'h10;     // slave_address_register
    localparam logic [7:0] PORT_OFF = 8'h14;    // pin level view
    localparam logic [7:0] IMASK_OFF = 8'h18;   // interrupt mask
    // control_register_one fields
    localparam int CR1_EN = 7;
    localparam int CR1_MST = 5;
    localparam int CR1_TRS = 4;
    // control_register_two fields
    localparam int CR2_BUS_BUSY_FLAG = 7;
    localparam int CR2_SCP = 6;
    localparam int CR2_SDA_OUTPUT_LEVEL_BIT = 5;
    localparam int CR2_SCL_OUTPUT_LEVEL_BIT = 3;
    localparam int CR2_SRST = 1;
    // interrupt_enable_register field
    localparam int IER_NAK = 4;
    // status_register fields
    localparam int SR_TRANSMIT_EMPTY_FLAG = 7;
    localparam int SR_TRANSMIT_END_FLAG = 6;
    localparam int SR_RECEIVE_FULL_FLAG = 5;
    localparam int SR_NACK = 4;
    localparam int SR_STOP = 3;
    localparam int SR_ALOV = 2;
    localparam int SR_AAS = 1;
    localparam int SR_ADZ = 0;
    // slave_address_register field
    localparam int SAR_FS = 0;
    // Event status bits (sticky, write one to clear) in the status register upper byte
    localparam int EV_START = 8;
    localparam int EV_STOP = 9;
    localparam int EV_NAK = 10;
    localparam int EV_W = 3;
    // Reset values
    localparam logic [7:0] CR1_RST = 8'h00;
    localparam logic [7:0] CR2_RST = 8'h28;
    localparam logic [7:0] SR_RST = 8'h00;
    // Line timing: half an SCL period at 100 kHz in ns, and cycles at the 20 ns clock
    localparam int CLK_NS = 20;
    localparam int HALF_SCL_NS = 5000;
    localparam int HALF_SCL_CYC = HALF_SCL_NS / CLK_NS;
    localparam int DIV_W = 9;

    typedef enum logic [3:0] {
        IBC_MODE_SR = 4'h1,
        IBC_MODE_ST = 4'h2,
        IBC_MODE_MR = 4'h4,
        IBC_MODE_MT = 4'h8
    } ibc_mode_t;

    typedef enum logic [3:0] {
        IBC_GEN_IDLE = 4'h1,
        IBC_GEN_START = 4'h2,
        IBC_GEN_STOP_A = 4'h4,
        IBC_GEN_STOP_B = 4'h8
    } ibc_gen_t;

    // Sampled bus line levels and their conditions
    typedef struct packed {
        logic scl;
        logic sda;
        logic start;
        logic stop;
    } ibc_line_t;

    // Line drivers; enable low drives the pin low
    typedef struct packed {
        logic scl_oe_n;
        logic sda_oe_n;
    } ibc_drv_t;
endpackage
`default_nettype wire

/* File: rtl/ibc_line_mon.sv */
// Synchroniser and start/stop detector for the SCL and SDA input pins
`default_nettype none
module ibc_line_mon (
    input wire logic pclk,              // 50 MHz clock
    input wire logic presetn,           // Async reset, low
    input wire logic scl_i,             // SCL pin level
    input wire logic sda_i,             // SDA pin level
    output var ibc_pkg::ibc_line_t line // Synced levels and conditions
);
    import ibc_pkg::*;

    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    always_comb
    begin
        line.scl = scl_s_r[1];
        line.sda = sda_s_r[1];
        line.start = scl_d_r && scl_s_r[1] && sda_d_r && !sda_s_r[1];
        line.stop = scl_d_r && scl_s_r[1] && !sda_d_r && sda_s_r[1];
    end
endmodule
`default_nettype wire

/* File: rtl/ibc_tick.sv */
// Divider giving a one-cycle enable pulse every half SCL period
`default_nettype none
module ibc_tick (
    input wire logic pclk,      // 50 MHz clock
    input wire logic presetn,   // Async reset, low
    input wire logic run,       // Count while high
    output logic tick           // One-cycle pulse
);
    import ibc_pkg::*;

    localparam logic [DIV_W-1:0] LAST = DIV_W'(HALF_SCL_CYC - 1);
    logic [DIV_W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ibc_ctrl.sv */
// I2C interface control: enable, soft reset, bus-busy tracking, start/stop output, NACK interrupt
//
// Overview of operation
// - Enable bit 0 releases SCL and SDA drivers; input paths stay active.
// - Enable bit 1 allows transfers and lets the block drive SCL and SDA.
// - With outputs off the block still samples lines and tracks bus state.
// - NACK interrupt enable gates request raised by NACK or arbitration/overrun flag.
// - Clearing every set flag or the enable bit withdraws the NACK request.
// - Soft-reset bit 1 holds control logic and some registers reset until written 0.
// - Writing 1 to format-select clears the bus-busy flag.
// - Setting soft reset forces SDA and SCL output-level bits to 1.
// - Soft reset in a transmit mode sets the transmit-empty flag.
// - During soft reset writes to bus-busy, start/stop and SDA level are ignored.
// - During soft reset start and stop on the lines still set and clear busy.
// - Disable or soft reset mid-transfer may leave busy and stop flags undefined.
// - Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - Master transmit, lines high: busy=1 with start/stop=0 issues a start.
// - Master, SDA low, SCL free: busy=0 with start/stop=0 issues a stop.
// - Mode decodes from master and transmit select: 11 MT, 10 MR, 01 ST, 00 SR.
//
// The register addresses and the APB slave port were chosen for this implementation.
`default_nettype none
module ibc_ctrl (
    input wire logic pclk,              // 50 MHz clock
    input wire logic presetn,           // Async reset, low
    input wire logic psel,              // APB select
    input wire logic penable,           // APB access phase
    input wire logic pwrite,            // APB write
    input wire logic [7:0] paddr,       // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    output logic [31:0] prdata,         // APB read data
    output logic pready,                // APB ready
    output logic pslverr,               // APB error on unmapped address
    input wire logic scl_i,             // SCL pin level
    input wire logic sda_i,             // SDA pin level
    output logic scl_oe_n,              // SCL driven low when low
    output logic sda_oe_n,              // SDA driven low when low
    output logic nack_irq_request,      // NACK interrupt request
    output logic irq                    // Masked event interrupt
);
    import ibc_pkg::*;

    ibc_line_t line;
    ibc_drv_t drv_nxt;
    ibc_gen_t gen_r;
    ibc_mode_t mode;
    logic [7:0] cr1_r;
    logic [7:0] cr2_r;
    logic [7:0] ier_r;
    logic [7:0] sr_r;
    logic [7:0] sar_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] ev_set;
    logic wr;
    logic rd;
    logic mapped;
    logic enable_bit;
    logic srst;
    logic srst_rise;
    logic tick;
    logic busy_r;
    logic scl_drv_r;
    logic sda_drv_r;
    logic start_req;
    logic stop_req;
    logic nak_cond;

    ibc_line_mon u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    ibc_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(gen_r != IBC_GEN_IDLE),
        .tick(tick)
    );

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign enable_bit = cr1_r[CR1_EN];
    assign srst = cr2_r[CR2_SRST];
    assign srst_rise = wr && paddr == CR2_OFF && pwdata[CR2_SRST] && !srst;

    always_comb
    begin
        case ({cr1_r[CR1_MST], cr1_r[CR1_TRS]})
            2'b11: mode = IBC_MODE_MT;
            2'b10: mode = IBC_MODE_MR;
            2'b01: mode = IBC_MODE_ST;
            default: mode = IBC_MODE_SR;
        endcase
    end

    // Start/stop requests from a write to control_register_two, blocked in soft reset
    assign start_req = wr && paddr == CR2_OFF && !srst && !pwdata[CR2_SRST]
        && pwdata[CR2_BUS_BUSY_FLAG] && !pwdata[CR2_SCP] && mode == IBC_MODE_MT
        && line.scl && line.sda;
    assign stop_req = wr && paddr == CR2_OFF && !srst && !pwdata[CR2_SRST]
        && !pwdata[CR2_BUS_BUSY_FLAG] && !pwdata[CR2_SCP] && cr1_r[CR1_MST]
        && !line.sda && line.scl;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cr1_r <= CR1_RST;
        else if (wr && paddr == CR1_OFF)
            cr1_r <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cr2_r <= CR2_RST;
        else if (wr && paddr == CR2_OFF)
        begin
            cr2_r[CR2_SRST] <= pwdata[CR2_SRST];
            if (pwdata[CR2_SRST])
            begin
                cr2_r[CR2_SDA_OUTPUT_LEVEL_BIT] <= 1'b1;
                cr2_r[CR2_SCL_OUTPUT_LEVEL_BIT] <= 1'b1;
            end
            else if (!srst)
            begin
                cr2_r[CR2_SCP] <= pwdata[CR2_SCP];
                cr2_r[CR2_SDA_OUTPUT_LEVEL_BIT] <= pwdata[CR2_SDA_OUTPUT_LEVEL_BIT];
                cr2_r[CR2_SCL_OUTPUT_LEVEL_BIT] <= pwdata[CR2_SCL_OUTPUT_LEVEL_BIT];
            end
            else
                cr2_r[CR2_SCL_OUTPUT_LEVEL_BIT] <= pwdata[CR2_SCL_OUTPUT_LEVEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ier_r <= 8'h00;
        else if (wr && paddr == IER_OFF)
            ier_r <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sar_r <= 8'h00;
        else if (wr && paddr == SAR_OFF)
            sar_r <= pwdata[7:0];
    end

    // Bus-busy: line conditions win over software, even in soft reset or with outputs off;
    // a disable or soft reset mid-transfer leaves it defined, not undefined
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_r <= 1'b0;
        else if (line.start)
            busy_r <= 1'b1;
        else if (line.stop)
            busy_r <= 1'b0;
        else if (wr && paddr == SAR_OFF && pwdata[SAR_FS])
            busy_r <= 1'b0;
    end

    // Status flags: software writes 0 to clear; hardware sets win
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sr_r <= SR_RST;
        else
        begin
            if (wr && paddr == SR_OFF)
                sr_r <= sr_r & pwdata[7:0];
            if (line.stop)
                sr_r[SR_STOP] <= 1'b1;
            if (srst_rise && (mode == IBC_MODE_MT || mode == IBC_MODE_ST))
                sr_r[SR_TRANSMIT_EMPTY_FLAG] <= 1'b1;
        end
    end

    // Start/stop generator paced by the half-period tick; idle in soft reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gen_r <= IBC_GEN_IDLE;
        else if (srst || !enable_bit)
            gen_r <= IBC_GEN_IDLE;
        else
        begin
            case (gen_r)
                IBC_GEN_IDLE:
                    if (start_req)
                        gen_r <= IBC_GEN_START;
                    else if (stop_req)
                        gen_r <= IBC_GEN_STOP_A;
                IBC_GEN_START:
                    if (tick)
                        gen_r <= IBC_GEN_IDLE;
                IBC_GEN_STOP_A:
                    if (tick)
                        gen_r <= IBC_GEN_STOP_B;
                IBC_GEN_STOP_B:
                    if (tick)
                        gen_r <= IBC_GEN_IDLE;
                default:
                    gen_r <= IBC_GEN_IDLE;
            endcase
        end
    end

    // Line drive levels: start pulls SDA low with SCL high and holds it until stop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_drv_r <= 1'b1;
            sda_drv_r <= 1'b1;
        end
        else if (srst)
        begin
            scl_drv_r <= 1'b1;
            sda_drv_r <= 1'b1;
        end
        else
        begin
            case (gen_r)
                IBC_GEN_START:
                    sda_drv_r <= 1'b0;
                IBC_GEN_STOP_A:
                    sda_drv_r <= 1'b0;
                IBC_GEN_STOP_B:
                    sda_drv_r <= 1'b1;
                default:
                    sda_drv_r <= sda_drv_r & cr2_r[CR2_SDA_OUTPUT_LEVEL_BIT];
            endcase
            scl_drv_r <= cr2_r[CR2_SCL_OUTPUT_LEVEL_BIT];
        end
    end

    always_comb
    begin
        drv_nxt.scl_oe_n = !enable_bit || scl_drv_r;
        drv_nxt.sda_oe_n = !enable_bit || sda_drv_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            scl_oe_n <= drv_nxt.scl_oe_n;
            sda_oe_n <= drv_nxt.sda_oe_n;
        end
    end

    // NACK request follows flags and enable, so clearing the enable or every set flag withdraws it
    assign nak_cond = ier_r[IER_NAK] && (sr_r[SR_NACK] || sr_r[SR_ALOV]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nack_irq_request <= 1'b0;
        else
            nack_irq_request <= nak_cond;
    end

    // Sticky events, write one to clear; a set in the same cycle wins
    assign ev_set = {nak_cond, line.stop, line.start};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_r <= '0;
        else if (wr && paddr == SR_OFF)
            ev_r <= (ev_r & ~pwdata[EV_STOP+1:EV_START]) | ev_set;
        else
            ev_r <= ev_r | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= '0;
        else if (wr && paddr == IMASK_OFF)
            mask_r <= pwdata[EV_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(ev_r & mask_r);
    end

    // APB slave: no wait states, data registered in setup cycle
    assign mapped = paddr == CR1_OFF || paddr == CR2_OFF || paddr == IER_OFF
        || paddr == SR_OFF || paddr == SAR_OFF || paddr == PORT_OFF || paddr == IMASK_OFF;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd)
            begin
                case (paddr)
                    CR1_OFF: prdata <= {24'h0, cr1_r};
                    CR2_OFF: prdata <= {24'h0, busy_r, cr2_r[6:0]};
                    IER_OFF: prdata <= {24'h0, ier_r};
                    SR_OFF: prdata <= {21'h0, ev_r, sr_r};
                    SAR_OFF: prdata <= {24'h0, sar_r};
                    PORT_OFF: prdata <= {28'h0, mode == IBC_MODE_SR, gen_r == IBC_GEN_IDLE,
                        line.scl, line.sda};
                    IMASK_OFF: prdata <= {29'h0, mask_r};
                    default: prdata <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/ibc_checker.sv */
// Port-level assertions for the I2C control block
`default_nettype none
module ibc_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB access
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic scl_i, // SCL level
    input wire logic sda_i, // SDA level
    input wire logic scl_oe_n, // SCL driver
    input wire logic sda_oe_n, // SDA driver
    input wire logic nack_irq_request, // NACK request
    input wire logic irq // Event interrupt
);
    import ibc_pkg::*;
    logic en_r;
    logic ier_r;
    logic [2:0] msk_r;
    // Shadows of the enable, NACK enable and mask bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= 1'b0;
            ier_r <= 1'b0;
            msk_r <= 3'h0;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == CR1_OFF)
                en_r <= pwdata[CR1_EN];
            if (paddr == IER_OFF)
                ier_r <= pwdata[IER_NAK];
            if (paddr == IMASK_OFF)
                msk_r <= pwdata[2:0];
        end
    end
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    no_wait_a: assert property (psel && penable |-> pready)
        else $error("access without ready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    bad_addr_a: assert property (psel && penable && paddr > IMASK_OFF
        |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");
    good_addr_a: assert property (pready && paddr <= IMASK_OFF && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    upper_zero_a: assert property (pready && !pwrite && paddr != SR_OFF |-> prdata[31:8] == 0)
        else $error("upper read bits set");
    off_release_a: assert property ((!en_r) [*2] |-> scl_oe_n && sda_oe_n)
        else $error("pin driven while disabled");
    drive_en_a: assert property ($fell(sda_oe_n) |-> en_r)
        else $error("drive began while disabled");
    nack_gate_a: assert property ((!ier_r) [*2] |-> !nack_irq_request)
        else $error("NACK request while gated");
    irq_mask_a: assert property ((msk_r == 3'h0) [*2] |-> !irq)
        else $error("interrupt while masked");
    start_hold_a: assert property ($fell(sda_oe_n) |=> (!sda_oe_n || !en_r) [*8])
        else $error("start drive too short");
endmodule
`default_nettype wire

/* File: dv/ibc_bus_model.sv */
// Other I2C party: open-drain drivers, 160 ns link clock only within frames
`default_nettype none
module ibc_bus_model (
    output logic scl_n, // Low pulls SCL low
    output logic sda_n // Low pulls SDA low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl_n = 1'b1;
        sda_n = 1'b1;
    end
    // Start condition, then eight clocks with SDA low; one byte at a time, so the bench
    // reads back before any following byte reaches its 8th rising SCL
    task automatic frame();
        #7 sda_n = 1'b0;
        #80 scl_n = 1'b0;
        repeat (8)
        begin
            #80 scl_n = 1'b1;
            #80 scl_n = 1'b0;
        end
    endtask
    task automatic stop();
        #80 sda_n = 1'b0;
        #80 scl_n = 1'b1;
        #80 sda_n = 1'b1;
    endtask
    // Walk away mid-frame without a stop condition
    task automatic drop();
        #80 sda_n = 1'b1;
        #80 scl_n = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: dv/i2c_enable_reset_bus_busy_ctrl_tb.sv */
// Self-checking testbench of the I2C enable, soft reset and bus-busy block
`default_nettype none
module i2c_enable_reset_bus_busy_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ibc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_oe_n;
    logic sda_oe_n;
    logic nack_irq_request;
    logic irq;
    logic m_scl_n;
    logic m_sda_n;
    logic scl_w;
    logic sda_w;
    logic [31:0] rdv;
    logic er;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    // Pulled-up wires
    assign scl_w = scl_oe_n & m_scl_n;
    assign sda_w = sda_oe_n & m_sda_n;
    ibc_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .sda_i(sda_w),
        .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .nack_irq_request(nack_irq_request), .irq(irq)
    );
    ibc_bus_model bm (
        .scl_n(m_scl_n),
        .sda_n(m_sda_n)
    );
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask
    task automatic wt(input logic [7:0] a, input int b, input logic v);
        int n = 0;
        apb(1'b0, a, 32'h0);
        while (rdv[b] !== v && n < 400)
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
    endtask
    task automatic st();
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic t_regs();
        rm(CR1_OFF, 32'hffffffff, 32'h0);
        rm(CR2_OFF, 32'h7f, 32'h28);
        rm(IER_OFF, 32'hffffffff, 32'h0);
        rm(SR_OFF, 32'hffffffff, 32'h0);
        rm(SAR_OFF, 32'hffffffff, 32'h0);
        rm(IMASK_OFF, 32'hffffffff, 32'h0);
        wr(8'h1c, 32'hff);
        chk({31'h0, er}, 32'h1);
        rm(8'h1c, 32'hffffffff, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(IER_OFF, 32'h10);
        st();
        chk(nack_irq_request, 1'b0);
        wr(IER_OFF, 32'h0);
        $display("regs done");
    endtask
    task automatic t_modes();
        for (int i = 0; i < 4; i++)
        begin
            wr(CR1_OFF, i << 4);
            rm(PORT_OFF, 32'h8, (i == 0) ? 32'h8 : 32'h0);
        end
        $display("modes done");
    endtask
    task automatic t_listen();
        wr(CR1_OFF, 32'h30);
        bm.frame();
        chk({scl_oe_n, sda_oe_n}, 2'b11);
        wt(CR2_OFF, 7, 1'b1);
        rm(CR2_OFF, 32'h80, 32'h80);
        rm(SR_OFF, 32'h100, 32'h100);
        wr(IMASK_OFF, 32'h1);
        st();
        chk(irq, 1'b1);
        wr(IMASK_OFF, 32'h0);
        st();
        chk(irq, 1'b0);
        wr(IMASK_OFF, 32'h1);
        wr(SR_OFF, 32'h1ff);
        st();
        chk(irq, 1'b0);
        wr(IMASK_OFF, 32'h0);
        bm.stop();
        wt(CR2_OFF, 7, 1'b0);
        rm(CR2_OFF, 32'h80, 32'h0);
        $display("listen done");
    endtask
    task automatic t_srst();
        wr(CR2_OFF, 32'h08);
        rm(CR2_OFF, 32'h20, 32'h0);
        rm(SR_OFF, 32'h80, 32'h0);
        wr(CR2_OFF, 32'h0a);
        rm(CR2_OFF, 32'h2a, 32'h2a);
        rm(SR_OFF, 32'h80, 32'h80);
        wr(CR1_OFF, 32'hb0);
        wr(CR2_OFF, 32'ha2);
        st();
        chk(sda_oe_n, 1'b1);
        wr(CR2_OFF, 32'h82);
        rm(CR2_OFF, 32'ha0, 32'h20);
        bm.frame();
        wt(CR2_OFF, 7, 1'b1);
        rm(CR2_OFF, 32'h80, 32'h80);
        bm.stop();
        wt(CR2_OFF, 7, 1'b0);
        rm(CR2_OFF, 32'h80, 32'h0);
        wr(CR2_OFF, 32'h28);
        wr(CR1_OFF, 32'h0);
        $display("srst done");
    endtask
    task automatic t_recover();
        bm.frame();
        bm.drop();
        wr(CR1_OFF, 32'h0);
        wr(CR2_OFF, 32'h2a);
        wr(CR1_OFF, 32'h0);
        wt(PORT_OFF, 0, 1'b1);
        rm(PORT_OFF, 32'h3, 32'h3);
        rm(CR2_OFF, 32'h80, 32'h80);
        wr(SAR_OFF, 32'h1);
        rm(CR2_OFF, 32'h80, 32'h0);
        wr(SAR_OFF, 32'h0);
        wr(SR_OFF, 32'h0);
        wr(CR2_OFF, 32'h28);
        wr(CR1_OFF, 32'h80);
        rm(SR_OFF, 32'hff, 32'h0);
        $display("recover done");
    endtask
    task automatic t_gen();
        wr(CR1_OFF, 32'ha0);
        wr(CR2_OFF, 32'ha8);
        st();
        chk(sda_oe_n, 1'b1);
        wr(CR1_OFF, 32'h30);
        wr(CR2_OFF, 32'ha8);
        st();
        chk(sda_oe_n, 1'b1);
        wr(CR1_OFF, 32'hb0);
        wr(CR2_OFF, 32'ha8);
        st();
        chk({scl_oe_n, sda_oe_n}, 2'b10);
        wt(CR2_OFF, 7, 1'b1);
        rm(CR2_OFF, 32'h80, 32'h80);
        wt(PORT_OFF, 2, 1'b1);
        wr(CR2_OFF, 32'h28);
        wt(CR2_OFF, 7, 1'b0);
        rm(CR2_OFF, 32'h80, 32'h0);
        chk(sda_oe_n, 1'b1);
        wr(CR1_OFF, 32'h0);
        $display("gen done");
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_listen();
        t_srst();
        t_recover();
        t_gen();
        results();
    end
endmodule
bind ibc_ctrl ibc_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .sda_i(sda_i),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .nack_irq_request(nack_irq_request), .irq(irq)
);
`default_nettype wire
